//--- verilog/fieldbus_slave_core.sv
// slave application state machine with its parameter dictionary

`include "slave_regs.svh"

module fieldbus_slave_core (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // state requests from the master
    input wire logic state_req,
    input wire logic [3:0] state_req_code,
    input wire logic mbx_cfg_ok,
    input wire logic pd_cfg_ok,
    input wire logic dc_used,
    input wire logic dc_cfg_ok,
    output logic [3:0] al_state,
    output logic state_ack,
    output logic state_refused,
    // mailbox and process data traffic
    input wire logic mbx_valid,
    input wire logic [3:0] mbx_type,
    output logic mbx_accept,
    input wire logic pd_valid,
    input wire logic [15:0] pd_out_data,
    output logic pd_accept,
    input wire logic wd_disabled,
    // physical pins and input image
    input wire logic [15:0] phys_in,
    output logic [15:0] phys_out,
    output logic [15:0] in_image,
    // dictionary access
    input wire logic od_req,
    input wire logic od_write,
    input wire logic [15:0] od_index,
    input wire logic [7:0] od_sub,
    input wire logic [31:0] od_wdata,
    output logic od_ack,
    output logic od_err,
    output logic [31:0] od_rdata,
    // nonvolatile commit
    output logic nv_req,
    output logic [5:0] nv_addr,
    output logic [31:0] nv_data,
    input wire logic nv_ack
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic chan_hit(input logic [15:0] idx);
        chan_hit = (idx[15:12] == `IDX_RANGE_CHAN || idx[15:12] == `IDX_RANGE_CHAN_OLD)
            && idx[11:6] == 6'h0 && idx[3:0] == 4'h0;
    endfunction

    function automatic logic is_state(input logic [3:0] code);
        is_state = code == `ST_CODE_INIT || code == `ST_CODE_PREOP || code == `ST_CODE_BOOT
            || code == `ST_CODE_SAFEOP || code == `ST_CODE_OP;
    endfunction

    // ----------------------------------------------------------------
    // pin synchroniser
    // ----------------------------------------------------------------
    logic [15:0] in_sync1_q;
    logic [15:0] in_sync2_q;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            in_sync1_q <= 16'h0;
            in_sync2_q <= 16'h0;
        end
        else
        begin
            in_sync1_q <= phys_in;
            in_sync2_q <= in_sync1_q;
        end
    end

    // ----------------------------------------------------------------
    // state machine
    // ----------------------------------------------------------------
    slave_pkg::app_state_e state_q, state_d;
    logic ack_q, ack_d;
    logic refused_q, refused_d;
    logic [15:0] image_q, image_d;
    logic out_rx_q, out_rx_d;
    logic ok;

    always_comb
    begin
        ok = 1'b0;
        unique case (state_q)
            slave_pkg::ST_INIT:
            begin
                ok = state_req_code == `ST_CODE_INIT || state_req_code == `ST_CODE_BOOT
                    || (state_req_code == `ST_CODE_PREOP && mbx_cfg_ok);
            end
            slave_pkg::ST_PREOP:
            begin
                ok = state_req_code == `ST_CODE_INIT || state_req_code == `ST_CODE_PREOP
                    || (state_req_code == `ST_CODE_SAFEOP && pd_cfg_ok
                    && (!dc_used || dc_cfg_ok));
            end
            slave_pkg::ST_SAFEOP:
            begin
                ok = state_req_code == `ST_CODE_INIT || state_req_code == `ST_CODE_PREOP
                    || state_req_code == `ST_CODE_SAFEOP
                    || (state_req_code == `ST_CODE_OP && out_rx_q);
            end
            slave_pkg::ST_OP:
            begin
                ok = state_req_code == `ST_CODE_INIT || state_req_code == `ST_CODE_PREOP
                    || state_req_code == `ST_CODE_SAFEOP || state_req_code == `ST_CODE_OP;
            end
            slave_pkg::ST_BOOT:
            begin
                ok = state_req_code == `ST_CODE_INIT || state_req_code == `ST_CODE_BOOT;
            end
            default:
            begin
                ok = 1'b0;
            end
        endcase
        ok = ok && is_state(state_req_code);
        state_d = state_q;
        ack_d = 1'b0;
        refused_d = refused_q;
        image_d = image_q;
        out_rx_d = out_rx_q;
        if (state_req)
        begin
            if (ok)
            begin
                state_d = slave_pkg::app_state_e'(state_req_code);
                ack_d = 1'b1;
                refused_d = 1'b0;
                if (state_q == slave_pkg::ST_PREOP && state_req_code == `ST_CODE_SAFEOP)
                begin
                    image_d = in_sync2_q;
                end
            end
            else
            begin
                refused_d = 1'b1;
            end
        end
        if (pd_accept)
        begin
            image_d = in_sync2_q;
            out_rx_d = 1'b1;
        end
        if (state_q != slave_pkg::ST_SAFEOP && state_q != slave_pkg::ST_OP)
        begin
            out_rx_d = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state_q <= slave_pkg::ST_INIT;
            ack_q <= 1'b0;
            refused_q <= 1'b0;
            image_q <= 16'h0;
            out_rx_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            ack_q <= ack_d;
            refused_q <= refused_d;
            image_q <= image_d;
            out_rx_q <= out_rx_d;
        end
    end

    // ----------------------------------------------------------------
    // traffic gates and outputs
    // ----------------------------------------------------------------
    logic pd_open;
    logic drive_out;
    logic [15:0] out_q, out_d;

    assign pd_open = state_q == slave_pkg::ST_SAFEOP || state_q == slave_pkg::ST_OP;
    assign pd_accept = pd_valid && pd_open;
    assign mbx_accept = mbx_valid && (state_q == slave_pkg::ST_PREOP || pd_open
        || (state_q == slave_pkg::ST_BOOT && mbx_type == `MBX_TYPE_FILE));
    assign drive_out = state_q == slave_pkg::ST_OP
        || (state_q == slave_pkg::ST_SAFEOP && wd_disabled);

    always_comb
    begin
        out_d = `OUT_SAFE_VALUE;
        if (drive_out)
        begin
            out_d = pd_valid ? pd_out_data : out_q;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            out_q <= `OUT_SAFE_VALUE;
        end
        else
        begin
            out_q <= out_d;
        end
    end

    // ----------------------------------------------------------------
    // dictionary
    // ----------------------------------------------------------------
    logic od_open;
    logic mem_we;
    logic [5:0] mem_addr;
    logic [31:0] mem_rdata;
    slave_pkg::od_src_e src_d, src_q;
    logic p1_q, p1_err_q, p1_err_d;
    logic [31:0] p1_data_q, p1_data_d;
    logic nosave_q, nosave_d;
    logic nv_q, nv_d;
    logic [5:0] nv_addr_q, nv_addr_d;
    logic [31:0] nv_data_q, nv_data_d;
    logic ack2_q, err2_q;
    logic [31:0] rdata2_q;

    assign od_open = state_q == slave_pkg::ST_PREOP || pd_open;
    assign mem_addr = {od_index[5:4], od_sub[3:0]};

    always_comb
    begin
        src_d = slave_pkg::SRC_NONE;
        p1_err_d = 1'b0;
        p1_data_d = 32'h0;
        mem_we = 1'b0;
        nosave_d = nosave_q;
        nv_d = nv_q && !nv_ack;
        nv_addr_d = nv_addr_q;
        nv_data_d = nv_data_q;
        if (od_req)
        begin
            p1_err_d = 1'b1;
            if (!od_open)
            begin
                p1_err_d = 1'b1;
            end
            else if (chan_hit(od_index) && od_sub[7:4] == 4'h0 && od_sub[3:0] != 4'h0)
            begin
                if (!od_write)
                begin
                    src_d = slave_pkg::SRC_MEM;
                    p1_err_d = 1'b0;
                end
                else if (!nv_q)
                begin
                    mem_we = 1'b1;
                    p1_err_d = 1'b0;
                    if (!nosave_q)
                    begin
                        nv_d = 1'b1;
                        nv_addr_d = mem_addr;
                        nv_data_d = od_wdata;
                    end
                end
            end
            else if (!od_write)
            begin
                src_d = slave_pkg::SRC_REG;
                p1_err_d = 1'b0;
                if (chan_hit(od_index) && od_sub == 8'h00)
                begin
                    p1_data_d = `CHAN_ENTRIES;
                end
                else if (od_index == `IDX_IDENT && od_sub == 8'h00)
                begin
                    p1_data_d = `IDENT_VALUE;
                end
                else if (od_index == `IDX_INPUTS && od_sub == 8'h01)
                begin
                    p1_data_d = {16'h0, image_q};
                end
                else if (od_index == `IDX_OUTPUTS && od_sub == 8'h01)
                begin
                    p1_data_d = {16'h0, out_q};
                end
                else if (od_index == `IDX_NOSAVE && od_sub == 8'h00)
                begin
                    p1_data_d = {31'h0, nosave_q};
                end
                else
                begin
                    src_d = slave_pkg::SRC_NONE;
                    p1_err_d = 1'b1;
                end
            end
            else if (od_index == `IDX_NOSAVE && od_sub == 8'h00)
            begin
                nosave_d = od_wdata == `NOSAVE_CODE;
                p1_err_d = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            src_q <= slave_pkg::SRC_NONE;
            p1_q <= 1'b0;
            p1_err_q <= 1'b0;
            p1_data_q <= 32'h0;
            nosave_q <= 1'b0;
            nv_q <= 1'b0;
            nv_addr_q <= 6'h0;
            nv_data_q <= 32'h0;
            ack2_q <= 1'b0;
            err2_q <= 1'b0;
            rdata2_q <= 32'h0;
        end
        else
        begin
            src_q <= src_d;
            p1_q <= od_req;
            p1_err_q <= p1_err_d;
            p1_data_q <= p1_data_d;
            nosave_q <= nosave_d;
            nv_q <= nv_d;
            nv_addr_q <= nv_addr_d;
            nv_data_q <= nv_data_d;
            ack2_q <= p1_q;
            err2_q <= p1_q && p1_err_q;
            rdata2_q <= src_q == slave_pkg::SRC_MEM ? mem_rdata : p1_data_q;
        end
    end

    param_ram u_ram (
        .clk(clk),
        .reset(reset),
        .we(mem_we),
        .waddr(mem_addr),
        .wdata(od_wdata),
        .raddr(mem_addr),
        .rdata(mem_rdata)
    );

    assign al_state = state_q;
    assign state_ack = ack_q;
    assign state_refused = refused_q;
    assign phys_out = out_q;
    assign in_image = image_q;
    assign od_ack = ack2_q;
    assign od_err = err2_q;
    assign od_rdata = rdata2_q;
    assign nv_req = nv_q;
    assign nv_addr = nv_addr_q;
    assign nv_data = nv_data_q;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_to_safeop;
        state_q == slave_pkg::ST_PREOP && state_req && state_req_code == `ST_CODE_SAFEOP;
    endsequence

    property p_init_quiet;
        state_q == slave_pkg::ST_INIT |-> !mbx_accept && !pd_accept;
    endproperty
    a_init_quiet: assert property (p_init_quiet) else $error("traffic in init");

    property p_preop_check;
        state_q == slave_pkg::ST_INIT && state_req && state_req_code == `ST_CODE_PREOP
            && !mbx_cfg_ok |=> state_q == slave_pkg::ST_INIT && state_refused && !state_ack;
    endproperty
    a_preop_check: assert property (p_preop_check) else $error("bad pre-op entry");

    property p_preop_nopd;
        state_q == slave_pkg::ST_PREOP |-> !pd_accept;
    endproperty
    a_preop_nopd: assert property (p_preop_nopd) else $error("process data in pre-op");

    property p_safeop_check;
        s_to_safeop and (!pd_cfg_ok || (dc_used && !dc_cfg_ok))
            |=> state_q == slave_pkg::ST_PREOP && state_refused && !state_ack;
    endproperty
    a_safeop_check: assert property (p_safeop_check) else $error("bad safe-op entry");

    property p_snapshot;
        s_to_safeop and (pd_cfg_ok && (!dc_used || dc_cfg_ok))
            |=> state_ack && in_image == $past(in_sync2_q);
    endproperty
    a_snapshot: assert property (p_snapshot) else $error("inputs not copied");

    property p_safe_out;
        state_q == slave_pkg::ST_SAFEOP && !wd_disabled |=> phys_out == `OUT_SAFE_VALUE;
    endproperty
    a_safe_out: assert property (p_safe_out) else $error("outputs not safe");

    property p_op_out;
        drive_out && pd_valid |=> phys_out == $past(pd_out_data);
    endproperty
    a_op_out: assert property (p_op_out) else $error("outputs not driven");

    property p_boot_entry;
        state_q != slave_pkg::ST_INIT && state_q != slave_pkg::ST_BOOT && state_req
            && state_req_code == `ST_CODE_BOOT |=> state_q != slave_pkg::ST_BOOT && state_refused;
    endproperty
    a_boot_entry: assert property (p_boot_entry) else $error("boot from wrong state");

    property p_boot_mbx;
        state_q == slave_pkg::ST_BOOT && mbx_type != `MBX_TYPE_FILE |-> !mbx_accept && !pd_accept;
    endproperty
    a_boot_mbx: assert property (p_boot_mbx) else $error("wrong traffic in boot");

    property p_read_only;
        od_req && od_write && od_index == `IDX_IDENT |-> ##2 od_ack && od_err;
    endproperty
    a_read_only: assert property (p_read_only) else $error("fixed entry written");

    property p_commit;
        mem_we && !nosave_q |=> nv_req && nv_data == $past(od_wdata);
    endproperty
    a_commit: assert property (p_commit) else $error("write not committed");

    property p_nosave;
        mem_we && nosave_q && !nv_req |=> !nv_req;
    endproperty
    a_nosave: assert property (p_nosave) else $error("saved while suppressed");

endmodule // fieldbus_slave_core

//--- verilog/slave_regs.svh
// constants of the fieldbus slave state machine and parameter dictionary
`ifndef SLAVE_REGS_SVH
`define SLAVE_REGS_SVH

// ----------------------------------------------------------------
// application state codes
// ----------------------------------------------------------------
`define ST_CODE_INIT 4'h1
`define ST_CODE_PREOP 4'h2
`define ST_CODE_BOOT 4'h3
`define ST_CODE_SAFEOP 4'h4
`define ST_CODE_OP 4'h8

// ----------------------------------------------------------------
// mailbox protocol type of file access
// ----------------------------------------------------------------
`define MBX_TYPE_FILE 4'h4

// ----------------------------------------------------------------
// dictionary index ranges
// ----------------------------------------------------------------
`define IDX_IDENT 16'h1000
`define IDX_INPUTS 16'h6000
`define IDX_OUTPUTS 16'h7000
`define IDX_NOSAVE 16'hf008
`define IDX_RANGE_CHAN 4'h8
`define IDX_RANGE_CHAN_OLD 4'h4
`define CHAN_STEP_POS 4
`define CHAN_ENTRIES 32'h0000000f

// ----------------------------------------------------------------
// values
// ----------------------------------------------------------------
`define NOSAVE_CODE 32'h12345678
`define OUT_SAFE_VALUE 16'h0000
`define IDENT_VALUE 32'h00c0ffee

`endif

//--- verilog/slave_pkg.sv
// types shared by the fieldbus slave files
package slave_pkg;

`include "slave_regs.svh"

    typedef enum logic [3:0] {
        ST_INIT = 4'h1,
        ST_PREOP = 4'h2,
        ST_BOOT = 4'h3,
        ST_SAFEOP = 4'h4,
        ST_OP = 4'h8
    } app_state_e;

    typedef enum logic [1:0] {
        SRC_NONE = 2'h0,
        SRC_MEM = 2'h1,
        SRC_REG = 2'h2
    } od_src_e;

endpackage

//--- verilog/param_ram.sv
// channel parameter storage, registered read data
module param_ram (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // write port
    input wire logic we,
    input wire logic [5:0] waddr,
    input wire logic [31:0] wdata,
    // read port
    input wire logic [5:0] raddr,
    output logic [31:0] rdata
);

    logic [31:0] mem_q [0:63];
    logic [31:0] rdata_q;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            for (int i = 0; i < 64; i++)
            begin
                mem_q[i] <= 32'h0;
            end
            rdata_q <= 32'h0;
        end
        else
        begin
            if (we)
            begin
                mem_q[waddr] <= wdata;
            end
            rdata_q <= mem_q[raddr];
        end
    end

    assign rdata = rdata_q;

endmodule // param_ram

//--- verif/master_model.sv
// master side model: state requests, traffic cycles and dictionary access
module master_model (
    // clock
    input wire logic clk,
    // state control
    output logic state_req,
    output logic [3:0] state_req_code,
    output logic mbx_cfg_ok,
    output logic pd_cfg_ok,
    output logic dc_used,
    output logic dc_cfg_ok,
    // traffic
    output logic mbx_valid,
    output logic [3:0] mbx_type,
    input wire logic mbx_accept,
    output logic pd_valid,
    output logic [15:0] pd_out_data,
    input wire logic pd_accept,
    output logic wd_disabled,
    // dictionary
    output logic od_req,
    output logic od_write,
    output logic [15:0] od_index,
    output logic [7:0] od_sub,
    output logic [31:0] od_wdata,
    input wire logic od_ack,
    input wire logic od_err,
    input wire logic [31:0] od_rdata
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        {state_req, mbx_cfg_ok, pd_cfg_ok, dc_used, dc_cfg_ok, wd_disabled} = '0;
        {mbx_valid, pd_valid, od_req, od_write, state_req_code, mbx_type} = '0;
        {pd_out_data, od_index, od_sub, od_wdata} = '0;
    end

    // ----
    // the req, mbx and pd tasks wait an edge, drive, and end just after the taking edge; od ends an edge later
    // ----
    task automatic setup_mbx(input logic ok);
        mbx_cfg_ok = ok;
    endtask

    task automatic setup_pd(input logic ok, input logic du, input logic dok);
        pd_cfg_ok = ok;
        dc_used = du;
        dc_cfg_ok = dok;
    endtask

    task automatic set_wd(input logic v);
        wd_disabled = v;
    endtask

    task automatic req(input logic [3:0] c);
        @(posedge clk);
        #1;
        state_req = 1'b1;
        state_req_code = c;
        @(posedge clk);
        #1;
        state_req = 1'b0;
    endtask

    task automatic mbx(input logic [3:0] t, output logic a);
        @(posedge clk);
        #1;
        mbx_valid = 1'b1;
        mbx_type = t;
        #1;
        a = mbx_accept;
        @(posedge clk);
        #1;
        mbx_valid = 1'b0;
    endtask

    task automatic pd(input logic [15:0] d, output logic a);
        @(posedge clk);
        #1;
        pd_valid = 1'b1;
        pd_out_data = d;
        #1;
        a = pd_accept;
        @(posedge clk);
        #1;
        pd_valid = 1'b0;
        pd_out_data = ~d;
    endtask

    task automatic od(input logic w, input logic [15:0] i, input logic [7:0] s,
        input logic [31:0] d, output logic a, output logic e, output logic [31:0] r);
        @(posedge clk);
        #1;
        od_req = 1'b1;
        od_write = w;
        od_index = i;
        od_sub = s;
        od_wdata = d;
        @(posedge clk);
        #1;
        od_req = 1'b0;
        od_wdata = ~d;
        @(posedge clk);
        #1;
        a = od_ack;
        e = od_err;
        r = od_rdata;
    endtask
endmodule // master_model

//--- verif/tb_top.sv
// self-checking bench of the fieldbus slave core
`include "slave_regs.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk, reset, state_req, mbx_cfg_ok, pd_cfg_ok, dc_used, dc_cfg_ok, state_ack;
    logic state_refused, mbx_valid, mbx_accept, pd_valid, pd_accept, wd_disabled, od_req;
    logic od_write, od_ack, od_err, nv_req, nv_ack, nv_hold;
    logic [3:0] state_req_code, al_state, mbx_type;
    logic [15:0] pd_out_data, phys_in, phys_out, in_image, od_index;
    logic [7:0] od_sub;
    logic [5:0] nv_addr;
    logic [31:0] od_wdata, od_rdata, nv_data;
    int error_cnt, comparisons, cycles;

    fieldbus_slave_core u_dut (
        .clk, .reset, .state_req, .state_req_code, .mbx_cfg_ok, .pd_cfg_ok, .dc_used,
        .dc_cfg_ok, .al_state, .state_ack, .state_refused, .mbx_valid, .mbx_type,
        .mbx_accept, .pd_valid, .pd_out_data, .pd_accept, .wd_disabled, .phys_in,
        .phys_out, .in_image, .od_req, .od_write, .od_index, .od_sub, .od_wdata, .od_ack,
        .od_err, .od_rdata, .nv_req, .nv_addr, .nv_data, .nv_ack
    );

    master_model u_master (
        .clk, .state_req, .state_req_code, .mbx_cfg_ok, .pd_cfg_ok, .dc_used, .dc_cfg_ok,
        .mbx_valid, .mbx_type, .mbx_accept, .pd_valid, .pd_out_data, .pd_accept,
        .wd_disabled, .od_req, .od_write, .od_index, .od_sub, .od_wdata, .od_ack, .od_err,
        .od_rdata
    );

    initial clk = 1'b0;
    always #4 clk = ~clk;

    // nonvolatile store acknowledges a commit a cycle later unless stalled
    always @(posedge clk) nv_ack <= !reset && nv_req && !nv_ack && !nv_hold;

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            error_cnt++;
            report_and_stop();
        end
    end

    // ----
    // shared checks
    // ----
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        comparisons++;
        if (s !== e)
        begin
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
            error_cnt++;
        end
    endtask

    task automatic st(input logic [3:0] c, input logic ok);
        logic [3:0] p;
        p = al_state;
        u_master.req(c);
        chk("state_ack", 32'(ok), 32'(state_ack));
        chk("al_state", 32'(ok ? c : p), 32'(al_state));
        chk("state_refused", 32'(!ok), 32'(state_refused));
    endtask

    task automatic od(input logic w, input logic [15:0] i, input logic [7:0] s,
        input logic [31:0] d, input logic e, input logic [31:0] r);
        logic a, ge;
        logic [31:0] gr;
        u_master.od(w, i, s, d, a, ge, gr);
        chk("od_ack", 32'h1, 32'(a));
        chk("od_err", 32'(e), 32'(ge));
        if (!w && !e)
            chk("od_rdata", r, gr);
    endtask

    task automatic mb(input logic [3:0] t, input logic e);
        logic a;
        u_master.mbx(t, a);
        chk("mbx_accept", 32'(e), 32'(a));
    endtask

    task automatic pdc(input logic [15:0] d, input logic e, input logic [15:0] o);
        logic a;
        u_master.pd(d, a);
        chk("pd_accept", 32'(e), 32'(a));
        chk("phys_out", 32'(o), 32'(phys_out));
    endtask

    // ----
    // scenarios
    // ----
    task automatic t_init();
        chk("al_state", 32'(`ST_CODE_INIT), 32'(al_state));
        mb(4'h2, 1'b0);
        od(1'b0, `IDX_IDENT, 8'h00, 32'h0, 1'b1, 32'h0);
        st(`ST_CODE_PREOP, 1'b0);
        u_master.setup_mbx(1'b1);
        st(`ST_CODE_PREOP, 1'b1);
    endtask

    task automatic t_preop();
        mb(4'h2, 1'b1);
        pdc(16'h00ff, 1'b0, `OUT_SAFE_VALUE);
        st(`ST_CODE_BOOT, 1'b0);
        od(1'b0, `IDX_IDENT, 8'h00, 32'h0, 1'b0, `IDENT_VALUE);
        od(1'b1, `IDX_IDENT, 8'h00, 32'h1, 1'b1, 32'h0);
        od(1'b0, 16'hffff, 8'hff, 32'h0, 1'b1, 32'h0);
        od(1'b0, 16'h8000, 8'h00, 32'h0, 1'b0, `CHAN_ENTRIES);
        od(1'b1, 16'h8000, 8'h00, 32'h1, 1'b1, 32'h0);
        nv_hold = 1'b1;
        od(1'b1, 16'h8010, 8'h03, 32'ha5a50003, 1'b0, 32'h0);
        chk("nv_req", 32'h1, 32'(nv_req));
        chk("nv_addr", 32'h13, 32'(nv_addr));
        chk("nv_data", 32'ha5a50003, nv_data);
        od(1'b1, 16'h8030, 8'h0f, 32'h1, 1'b1, 32'h0);
        nv_hold = 1'b0;
        od(1'b0, 16'h4010, 8'h03, 32'h0, 1'b0, 32'ha5a50003);
        od(1'b1, `IDX_NOSAVE, 8'h00, `NOSAVE_CODE, 1'b0, 32'h0);
        od(1'b0, `IDX_NOSAVE, 8'h00, 32'h0, 1'b0, 32'h1);
        od(1'b1, 16'h8020, 8'h05, 32'h55, 1'b0, 32'h0);
        chk("nv_req", 32'h0, 32'(nv_req));
        od(1'b0, 16'h8020, 8'h05, 32'h0, 1'b0, 32'h55);
        od(1'b1, `IDX_NOSAVE, 8'h00, 32'h0, 1'b0, 32'h0);
        od(1'b0, `IDX_NOSAVE, 8'h00, 32'h0, 1'b0, 32'h0);
        u_master.setup_pd(1'b0, 1'b0, 1'b0);
        st(`ST_CODE_SAFEOP, 1'b0);
        u_master.setup_pd(1'b1, 1'b1, 1'b0);
        st(`ST_CODE_SAFEOP, 1'b0);
        u_master.setup_pd(1'b1, 1'b1, 1'b1);
        st(`ST_CODE_SAFEOP, 1'b1);
        chk("in_image", 32'h5a3c, 32'(in_image));
    endtask

    task automatic t_safeop();
        st(`ST_CODE_OP, 1'b0);
        phys_in = 16'h0f0f;
        mb(4'h2, 1'b1);
        pdc(16'hbeef, 1'b1, `OUT_SAFE_VALUE);
        chk("in_image", 32'h0f0f, 32'(in_image));
        od(1'b0, `IDX_INPUTS, 8'h01, 32'h0, 1'b0, 32'h0f0f);
        u_master.set_wd(1'b1);
        pdc(16'h1234, 1'b1, 16'h1234);
        od(1'b0, `IDX_OUTPUTS, 8'h01, 32'h0, 1'b0, 32'h1234);
        u_master.set_wd(1'b0);
        pdc(16'h4321, 1'b1, `OUT_SAFE_VALUE);
    endtask

    task automatic t_op_boot();
        st(`ST_CODE_OP, 1'b1);
        pdc(16'hc3c3, 1'b1, 16'hc3c3);
        mb(4'h2, 1'b1);
        st(`ST_CODE_BOOT, 1'b0);
        st(`ST_CODE_INIT, 1'b1);
        st(4'h5, 1'b0);
        st(`ST_CODE_BOOT, 1'b1);
        mb(`MBX_TYPE_FILE, 1'b1);
        mb(4'h2, 1'b0);
        pdc(16'h00ff, 1'b0, `OUT_SAFE_VALUE);
        st(`ST_CODE_PREOP, 1'b0);
    endtask

    initial
    begin
        reset = 1'b1;
        phys_in = 16'h5a3c;
        nv_hold = 1'b0;
        repeat (8) @(posedge clk);
        #1;
        reset = 1'b0;
        t_init();
        t_preop();
        t_safeop();
        t_op_boot();
        report_and_stop();
    end
endmodule // tb_top
